// [leaky_bucket_activity_monitor.sv]
`timescale 1ns/1ns
`default_nettype none
module leaky_bucket_activity_monitor #(
	parameter logic [lbm_pkg::TICK_W-1:0] EVAL_CYC = 24'(lbm_pkg::EVAL_CYC)
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic fault_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [lbm_pkg::ADR_W-1:0] wb_adr_i,
	input wire logic [lbm_pkg::SEL_W-1:0] wb_sel_i,
	input wire logic [lbm_pkg::DAT_W-1:0] wb_dat_i,
	output logic [lbm_pkg::DAT_W-1:0] wb_dat_o,
	output logic wb_ack_o,
	output logic alarm_o,
	output logic irq_o
);
	// ****************************************
	// storage
	// ****************************************
	logic [lbm_pkg::LVL_W-1:0] alarm_set_level_cfg_c_ff;
	logic [lbm_pkg::LVL_W-1:0] alarm_clear_level_cfg_c_ff;
	logic [lbm_pkg::DECAY_W-1:0] decay_ff;
	logic [lbm_pkg::IRQ_W-1:0] irq_status_ff;
	logic [lbm_pkg::IRQ_W-1:0] irq_mask_ff;
	logic irq_ff;
	logic ack_ff;
	logic [lbm_pkg::DAT_W-1:0] rdata_ff;
	logic tick;

	bucket_if bif ();

	// ****************************************
	// evaluation timer and bucket
	// ****************************************
	eval_tick #(
		.PERIOD(EVAL_CYC)
	) u_tick (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.tick_o(tick)
	);

	bucket_core u_core (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.bus(bif)
	);

	// timer tick, fault input and configuration into the bucket
	assign bif.tick = tick;
	assign bif.fault = fault_i;
	assign bif.decay = decay_ff;
	assign bif.set_lvl = alarm_set_level_cfg_c_ff;
	assign bif.clr_lvl = alarm_clear_level_cfg_c_ff;

	// ****************************************
	// wishbone decode
	// ****************************************
	// a new request is taken once, in the cycle before ack rises
	wire logic req = wb_cyc_i & wb_stb_i & ~ack_ff;
	wire logic wr = req & wb_we_i;
	wire logic [lbm_pkg::ADR_W-lbm_pkg::WORD_LSB-1:0] word = wb_adr_i[lbm_pkg::ADR_W-1:lbm_pkg::WORD_LSB];
	wire logic hit_set = (word == lbm_pkg::ADR_SET_LVL[lbm_pkg::ADR_W-1:lbm_pkg::WORD_LSB]);
	wire logic hit_clr = (word == lbm_pkg::ADR_CLR_LVL[lbm_pkg::ADR_W-1:lbm_pkg::WORD_LSB]);
	wire logic hit_decay = (word == lbm_pkg::ADR_DECAY[lbm_pkg::ADR_W-1:lbm_pkg::WORD_LSB]);
	wire logic hit_bucket = (word == lbm_pkg::ADR_BUCKET[lbm_pkg::ADR_W-1:lbm_pkg::WORD_LSB]);
	wire logic hit_stat = (word == lbm_pkg::ADR_IRQ_STAT[lbm_pkg::ADR_W-1:lbm_pkg::WORD_LSB]);
	wire logic hit_mask = (word == lbm_pkg::ADR_IRQ_MASK[lbm_pkg::ADR_W-1:lbm_pkg::WORD_LSB]);
	wire logic lane0 = wb_sel_i[0];
	wire logic wr_set = wr & hit_set & lane0;
	wire logic wr_clr = wr & hit_clr & lane0;
	wire logic wr_decay = wr & hit_decay & lane0;
	wire logic wr_stat = wr & hit_stat & lane0;
	wire logic wr_mask = wr & hit_mask & lane0;

	// ****************************************
	// register next values
	// ****************************************
	// configuration writes
	wire logic [lbm_pkg::LVL_W-1:0] nxt_set = wr_set ? wb_dat_i[lbm_pkg::LVL_W-1:0] : alarm_set_level_cfg_c_ff;
	wire logic [lbm_pkg::LVL_W-1:0] nxt_clr = wr_clr ? wb_dat_i[lbm_pkg::LVL_W-1:0] : alarm_clear_level_cfg_c_ff;
	wire logic [lbm_pkg::DECAY_W-1:0] nxt_decay = wr_decay ? wb_dat_i[lbm_pkg::DECAY_W-1:0] : decay_ff;
	wire logic [lbm_pkg::IRQ_W-1:0] nxt_mask = wr_mask ? wb_dat_i[lbm_pkg::IRQ_W-1:0] : irq_mask_ff;

	// sticky events: a new event beats a same-cycle write-one-to-clear
	wire logic [lbm_pkg::IRQ_W-1:0] events = {bif.clear, bif.raise};
	wire logic [lbm_pkg::IRQ_W-1:0] w1c = wr_stat ? wb_dat_i[lbm_pkg::IRQ_W-1:0] : lbm_pkg::IRQ_RST;
	wire logic [lbm_pkg::IRQ_W-1:0] nxt_status = (irq_status_ff & ~w1c) | events;
	wire logic nxt_irq = |(nxt_status & nxt_mask);

	// ****************************************
	// read data selection
	// ****************************************
	// unmapped words read as zero and are still acknowledged
	wire logic [lbm_pkg::DAT_W-1:0] rd_set = {{(lbm_pkg::DAT_W-lbm_pkg::LVL_W){1'b0}}, alarm_set_level_cfg_c_ff};
	wire logic [lbm_pkg::DAT_W-1:0] rd_clr = {{(lbm_pkg::DAT_W-lbm_pkg::LVL_W){1'b0}}, alarm_clear_level_cfg_c_ff};
	wire logic [lbm_pkg::DAT_W-1:0] rd_decay = {{(lbm_pkg::DAT_W-lbm_pkg::DECAY_W){1'b0}}, decay_ff};
	wire logic [lbm_pkg::DAT_W-1:0] rd_bucket = {{(lbm_pkg::DAT_W-lbm_pkg::ALARM_BIT-1){1'b0}}, bif.alarm, bif.count};
	wire logic [lbm_pkg::DAT_W-1:0] rd_stat = {{(lbm_pkg::DAT_W-lbm_pkg::IRQ_W){1'b0}}, irq_status_ff};
	wire logic [lbm_pkg::DAT_W-1:0] rd_mask = {{(lbm_pkg::DAT_W-lbm_pkg::IRQ_W){1'b0}}, irq_mask_ff};
	wire logic [lbm_pkg::DAT_W-1:0] rd_mux = hit_set ? rd_set :
		hit_clr ? rd_clr :
		hit_decay ? rd_decay :
		hit_bucket ? rd_bucket :
		hit_stat ? rd_stat :
		hit_mask ? rd_mask : lbm_pkg::DAT_ZERO;
	wire logic [lbm_pkg::DAT_W-1:0] nxt_rdata = (req & ~wb_we_i) ? rd_mux : lbm_pkg::DAT_ZERO;

	// ****************************************
	// registers
	// ****************************************
	// software configuration
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			alarm_set_level_cfg_c_ff <= lbm_pkg::SET_LVL_RST;
			alarm_clear_level_cfg_c_ff <= lbm_pkg::CLR_LVL_RST;
			decay_ff <= lbm_pkg::DECAY_RST;
			irq_mask_ff <= lbm_pkg::IRQ_RST;
		end else if (ce_i) begin
			alarm_set_level_cfg_c_ff <= nxt_set;
			alarm_clear_level_cfg_c_ff <= nxt_clr;
			decay_ff <= nxt_decay;
			irq_mask_ff <= nxt_mask;
		end
	end

	// interrupt status and output
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_status_ff <= lbm_pkg::IRQ_RST;
			irq_ff <= 1'b0;
		end else if (ce_i) begin
			irq_status_ff <= nxt_status;
			irq_ff <= nxt_irq;
		end
	end

	// bus answer
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_ff <= 1'b0;
			rdata_ff <= lbm_pkg::DAT_ZERO;
		end else if (ce_i) begin
			ack_ff <= req;
			rdata_ff <= nxt_rdata;
		end
	end

	assign wb_ack_o = ack_ff;
	assign wb_dat_o = rdata_ff;
	assign irq_o = irq_ff;
	assign alarm_o = bif.alarm;

	// ****************************************
	// checks
	// ****************************************
	sequence s_req;
		ce_i && wb_cyc_i && wb_stb_i && !ack_ff;
	endsequence
	property p_ack;
		@(posedge clk_i) disable iff (rst_i) s_req |=> ack_ff ##1 (!ack_ff || !ce_i);
	endproperty
	a_ack: assert property (p_ack) else $error("bus request not answered in one cycle");
	property p_irq;
		@(posedge clk_i) disable iff (rst_i) ce_i |=> irq_o == |(irq_status_ff & irq_mask_ff);
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt output disagrees with status and mask");
	property p_sticky;
		@(posedge clk_i) disable iff (rst_i) ce_i && bif.raise |=> irq_status_ff[lbm_pkg::IRQ_RAISE];
	endproperty
	a_sticky: assert property (p_sticky) else $error("raise event lost");
	property p_set_write;
		@(posedge clk_i) disable iff (rst_i) ce_i && wr_set |=> alarm_set_level_cfg_c_ff == $past(wb_dat_i[lbm_pkg::LVL_W-1:0]);
	endproperty
	a_set_write: assert property (p_set_write) else $error("set level write not stored");
	property p_clr_write;
		@(posedge clk_i) disable iff (rst_i) ce_i && wr_clr |=> alarm_clear_level_cfg_c_ff == $past(wb_dat_i[lbm_pkg::LVL_W-1:0]);
	endproperty
	a_clr_write: assert property (p_clr_write) else $error("clear level write not stored");
	property p_alarm_out;
		@(posedge clk_i) disable iff (rst_i) $rose(alarm_o) |-> irq_status_ff[lbm_pkg::IRQ_RAISE] ##0 bif.count >= alarm_set_level_cfg_c_ff || $past(wr_set);
	endproperty
	a_alarm_out: assert property (p_alarm_out) else $error("alarm rose without reaching set level");

	// ****************************************
	// bus and register checks
	// ****************************************
	// a read request that the slave takes
	sequence s_read;
		ce_i && req && !wb_we_i;
	endsequence

	// ack is a single-cycle pulse
	property p_ack_pulse;
		@(posedge clk_i) disable iff (rst_i) ce_i && ack_ff |=> !ack_ff;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack held longer than one cycle");

	// read data is zero outside the ack cycle
	property p_rdata_idle;
		@(posedge clk_i) disable iff (rst_i) !wb_ack_o |-> wb_dat_o == lbm_pkg::DAT_ZERO;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data driven outside ack");

	// a write is answered with zero data
	property p_write_data;
		@(posedge clk_i) disable iff (rst_i) ce_i && wr |=> wb_ack_o && wb_dat_o == lbm_pkg::DAT_ZERO;
	endproperty
	a_write_data: assert property (p_write_data) else $error("write answered with read data");

	// set level reads back in the low byte
	property p_read_set;
		@(posedge clk_i) disable iff (rst_i)
			s_read ##0 hit_set |=> wb_dat_o[lbm_pkg::LVL_W-1:0] == $past(alarm_set_level_cfg_c_ff);
	endproperty
	a_read_set: assert property (p_read_set) else $error("set level read back wrong");

	// clear level reads back in the low byte
	property p_read_clr;
		@(posedge clk_i) disable iff (rst_i)
			s_read ##0 hit_clr |=> wb_dat_o[lbm_pkg::LVL_W-1:0] == $past(alarm_clear_level_cfg_c_ff);
	endproperty
	a_read_clr: assert property (p_read_clr) else $error("clear level read back wrong");

	// decay code reads back in the low bits
	property p_read_decay;
		@(posedge clk_i) disable iff (rst_i)
			s_read ##0 hit_decay |=> wb_dat_o[lbm_pkg::DECAY_W-1:0] == $past(decay_ff);
	endproperty
	a_read_decay: assert property (p_read_decay) else $error("decay code read back wrong");

	// bucket word carries the count and the alarm
	property p_read_bucket;
		@(posedge clk_i) disable iff (rst_i)
			s_read ##0 hit_bucket |=> wb_dat_o[lbm_pkg::LVL_W-1:0] == $past(bif.count)
				&& wb_dat_o[lbm_pkg::ALARM_BIT] == $past(bif.alarm);
	endproperty
	a_read_bucket: assert property (p_read_bucket) else $error("bucket word read back wrong");

	// bits above the low byte read as zero in every word but the bucket word
	property p_read_upper;
		@(posedge clk_i) disable iff (rst_i)
			s_read ##0 !hit_bucket |=> (wb_dat_o >> lbm_pkg::LVL_W) == lbm_pkg::DAT_ZERO;
	endproperty
	a_read_upper: assert property (p_read_upper) else $error("upper read bits not zero");

	// unmapped words read as zero
	property p_read_unmapped;
		@(posedge clk_i) disable iff (rst_i)
			s_read ##0 !(hit_set || hit_clr || hit_decay || hit_bucket || hit_stat || hit_mask)
				|=> wb_dat_o == lbm_pkg::DAT_ZERO;
	endproperty
	a_read_unmapped: assert property (p_read_unmapped) else $error("unmapped word read not zero");

	// decay code write
	property p_decay_write;
		@(posedge clk_i) disable iff (rst_i) ce_i && wr_decay |=> decay_ff == $past(wb_dat_i[lbm_pkg::DECAY_W-1:0]);
	endproperty
	a_decay_write: assert property (p_decay_write) else $error("decay write not stored");

	// mask write
	property p_mask_write;
		@(posedge clk_i) disable iff (rst_i) ce_i && wr_mask |=> irq_mask_ff == $past(wb_dat_i[lbm_pkg::IRQ_W-1:0]);
	endproperty
	a_mask_write: assert property (p_mask_write) else $error("mask write not stored");

	// a write without the low byte lane changes nothing
	property p_lane_ignore;
		@(posedge clk_i) disable iff (rst_i) ce_i && wr && !lane0
			|=> $stable(alarm_set_level_cfg_c_ff) && $stable(alarm_clear_level_cfg_c_ff) && $stable(decay_ff);
	endproperty
	a_lane_ignore: assert property (p_lane_ignore) else $error("write without low lane took effect");

	// write-one-to-clear empties the written bits when no event competes
	property p_w1c;
		@(posedge clk_i) disable iff (rst_i) ce_i && wr_stat && events == lbm_pkg::IRQ_RST
			|=> (irq_status_ff & $past(wb_dat_i[lbm_pkg::IRQ_W-1:0])) == lbm_pkg::IRQ_RST;
	endproperty
	a_w1c: assert property (p_w1c) else $error("status bit not cleared by writing one");

	// status holds without an event or a write
	property p_status_hold;
		@(posedge clk_i) disable iff (rst_i)
			ce_i && !wr_stat && events == lbm_pkg::IRQ_RST |=> $stable(irq_status_ff);
	endproperty
	a_status_hold: assert property (p_status_hold) else $error("status changed without cause");

	// clear event is sticky
	property p_clear_sticky;
		@(posedge clk_i) disable iff (rst_i) ce_i && bif.clear |=> irq_status_ff[lbm_pkg::IRQ_CLEAR];
	endproperty
	a_clear_sticky: assert property (p_clear_sticky) else $error("clear event lost");

	// the alarm falls in the cycle its clear status bit is set
	property p_alarm_fall;
		@(posedge clk_i) disable iff (rst_i) $fell(alarm_o) |-> irq_status_ff[lbm_pkg::IRQ_CLEAR];
	endproperty
	a_alarm_fall: assert property (p_alarm_fall) else $error("alarm fell without clear status");

	// interrupt stays low while every bit is masked
	property p_irq_masked;
		@(posedge clk_i) disable iff (rst_i) irq_mask_ff == lbm_pkg::IRQ_RST |-> !irq_o;
	endproperty
	a_irq_masked: assert property (p_irq_masked) else $error("interrupt high with all bits masked");

	// an unmasked raise status drives the interrupt
	property p_irq_raise;
		@(posedge clk_i) disable iff (rst_i)
			irq_status_ff[lbm_pkg::IRQ_RAISE] && irq_mask_ff[lbm_pkg::IRQ_RAISE] |-> irq_o;
	endproperty
	a_irq_raise: assert property (p_irq_raise) else $error("unmasked raise status without interrupt");

	// clock enable low freezes registers, status and the bus answer
	property p_freeze;
		@(posedge clk_i) disable iff (rst_i) !ce_i
			|=> $stable(alarm_set_level_cfg_c_ff) && $stable(irq_status_ff) && $stable(ack_ff) && $stable(irq_ff);
	endproperty
	a_freeze: assert property (p_freeze) else $error("state moved while clock enable low");
endmodule
`default_nettype wire

// [lbm_pkg.sv]
`default_nettype none
package lbm_pkg;
	// ****************************************
	// timing
	// ****************************************
	localparam int CLK_HZ = 100_000_000;
	localparam int CLK_PER_MS = CLK_HZ / 1000;
	localparam int EVAL_PERIOD_MS = 128;
	localparam int EVAL_CYC = EVAL_PERIOD_MS * CLK_PER_MS;
	localparam int TICK_W = 24;
	localparam logic [TICK_W-1:0] TICK_ZERO = 24'h000000;
	localparam logic [TICK_W-1:0] TICK_STEP = 24'h000001;
	// ****************************************
	// bucket levels and run counter
	// ****************************************
	localparam int LVL_W = 8;
	localparam logic [LVL_W-1:0] LVL_MAX = 8'hFF;
	localparam logic [LVL_W-1:0] LVL_ZERO = 8'h00;
	localparam logic [LVL_W-1:0] LVL_STEP = 8'h01;
	localparam logic [LVL_W-1:0] SET_LVL_RST = 8'h06;
	localparam logic [LVL_W-1:0] CLR_LVL_RST = 8'h04;
	localparam int DECAY_W = 2;
	localparam logic [DECAY_W-1:0] DECAY_RST = 2'h0;
	localparam int RUN_W = 4;
	localparam logic [RUN_W-1:0] RUN_ZERO = 4'h0;
	localparam logic [RUN_W-1:0] RUN_ONE = 4'h1;
	// ****************************************
	// register map (byte addresses)
	// ****************************************
	localparam int ADR_W = 8;
	localparam int DAT_W = 32;
	localparam int SEL_W = 4;
	localparam logic [ADR_W-1:0] ADR_SET_LVL = 8'h00;
	localparam logic [ADR_W-1:0] ADR_CLR_LVL = 8'h04;
	localparam logic [ADR_W-1:0] ADR_DECAY = 8'h08;
	localparam logic [ADR_W-1:0] ADR_BUCKET = 8'h0C;
	localparam logic [ADR_W-1:0] ADR_IRQ_STAT = 8'h10;
	localparam logic [ADR_W-1:0] ADR_IRQ_MASK = 8'h14;
	localparam int WORD_LSB = 2;
	localparam int ALARM_BIT = 8;
	localparam int IRQ_W = 2;
	localparam int IRQ_RAISE = 0;
	localparam int IRQ_CLEAR = 1;
	localparam logic [IRQ_W-1:0] IRQ_RST = 2'h0;
	localparam logic [DAT_W-1:0] DAT_ZERO = 32'h00000000;
endpackage
`default_nettype wire

// [bucket_if.sv]
`timescale 1ns/1ns
`default_nettype none
interface bucket_if;
	logic tick;
	logic fault;
	logic [lbm_pkg::DECAY_W-1:0] decay;
	logic [lbm_pkg::LVL_W-1:0] set_lvl;
	logic [lbm_pkg::LVL_W-1:0] clr_lvl;
	logic [lbm_pkg::LVL_W-1:0] count;
	logic alarm;
	logic raise;
	logic clear;
	// bucket core side
	modport core (
		input tick, fault, decay, set_lvl, clr_lvl,
		output count, alarm, raise, clear
	);
	// register side
	modport ctrl (
		output tick, fault, decay, set_lvl, clr_lvl,
		input count, alarm, raise, clear
	);
endinterface
`default_nettype wire

// [eval_tick.sv]
`timescale 1ns/1ns
`default_nettype none
module eval_tick #(
	parameter logic [lbm_pkg::TICK_W-1:0] PERIOD = 24'(lbm_pkg::EVAL_CYC)
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	output logic tick_o
);
	logic [lbm_pkg::TICK_W-1:0] cnt_ff;
	logic tick_ff;
	wire logic last = (cnt_ff == PERIOD - lbm_pkg::TICK_STEP);
	wire logic [lbm_pkg::TICK_W-1:0] nxt_cnt = last ? lbm_pkg::TICK_ZERO : cnt_ff + lbm_pkg::TICK_STEP;

	// ****************************************
	// evaluation period counter
	// ****************************************
	// one pulse per evaluation period
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt_ff <= lbm_pkg::TICK_ZERO;
			tick_ff <= 1'b0;
		end else if (ce_i) begin
			cnt_ff <= nxt_cnt;
			tick_ff <= last;
		end
	end
	assign tick_o = tick_ff;

	property p_tick_phase;
		@(posedge clk_i) disable iff (rst_i) ce_i && tick_ff |-> cnt_ff == lbm_pkg::TICK_ZERO;
	endproperty
	a_tick_phase: assert property (p_tick_phase) else $error("tick out of phase with period counter");
endmodule
`default_nettype wire

// [bucket_core.sv]
`timescale 1ns/1ns
`default_nettype none
module bucket_core (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	bucket_if.core bus
);
	logic [lbm_pkg::LVL_W-1:0] count_ff;
	logic [lbm_pkg::RUN_W-1:0] run_ff;
	logic seen_ff;
	logic alarm_ff;
	logic raise_ff;
	logic clear_ff;

	// ****************************************
	// fill and drain decisions
	// ****************************************
	// a fault seen at any time in the period, the tick cycle included
	wire logic fault_now = seen_ff | bus.fault;
	wire logic [lbm_pkg::RUN_W-1:0] run_len = lbm_pkg::RUN_ONE << bus.decay;
	wire logic [lbm_pkg::RUN_W-1:0] run_next = run_ff + lbm_pkg::RUN_ONE;
	wire logic drain_due = (run_next >= run_len);
	wire logic at_max = (count_ff == lbm_pkg::LVL_MAX);
	wire logic at_zero = (count_ff == lbm_pkg::LVL_ZERO);
	wire logic [lbm_pkg::LVL_W-1:0] up_count = at_max ? count_ff : count_ff + lbm_pkg::LVL_STEP;
	wire logic [lbm_pkg::LVL_W-1:0] dn_count = at_zero ? count_ff : count_ff - lbm_pkg::LVL_STEP;
	wire logic [lbm_pkg::LVL_W-1:0] eval_count = fault_now ? up_count : (drain_due ? dn_count : count_ff);
	wire logic [lbm_pkg::LVL_W-1:0] nxt_count = bus.tick ? eval_count : count_ff;
	wire logic [lbm_pkg::RUN_W-1:0] nxt_run = !bus.tick ? run_ff : ((fault_now || drain_due) ? lbm_pkg::RUN_ZERO : run_next);
	wire logic do_raise = !alarm_ff && (nxt_count >= bus.set_lvl);
	wire logic do_clear = alarm_ff && (nxt_count <= bus.clr_lvl);
	wire logic nxt_alarm = do_raise | (alarm_ff & ~do_clear);

	// accumulator, run counter and alarm
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			count_ff <= lbm_pkg::LVL_ZERO;
			run_ff <= lbm_pkg::RUN_ZERO;
			seen_ff <= 1'b0;
			alarm_ff <= 1'b0;
			raise_ff <= 1'b0;
			clear_ff <= 1'b0;
		end else if (ce_i) begin
			count_ff <= nxt_count;
			run_ff <= nxt_run;
			seen_ff <= !bus.tick && fault_now;
			alarm_ff <= nxt_alarm;
			raise_ff <= do_raise;
			clear_ff <= do_clear;
		end
	end
	assign bus.count = count_ff;
	assign bus.alarm = alarm_ff;
	// events leave in the cycle before the alarm edge so status moves with the alarm
	assign bus.raise = do_raise;
	assign bus.clear = do_clear;

	// ****************************************
	// checks
	// ****************************************
	sequence s_fault_tick;
		ce_i && bus.tick && fault_now;
	endsequence
	sequence s_quiet_tick;
		ce_i && bus.tick && !fault_now;
	endsequence
	property p_fill;
		@(posedge clk_i) disable iff (rst_i) s_fault_tick and !at_max |=> count_ff == $past(count_ff) + lbm_pkg::LVL_STEP;
	endproperty
	a_fill: assert property (p_fill) else $error("bucket did not fill by one");
	property p_saturate;
		@(posedge clk_i) disable iff (rst_i) s_fault_tick and at_max |=> at_max;
	endproperty
	a_saturate: assert property (p_saturate) else $error("bucket wrapped at top");
	property p_floor;
		@(posedge clk_i) disable iff (rst_i) s_quiet_tick and at_zero |=> at_zero;
	endproperty
	a_floor: assert property (p_floor) else $error("bucket wrapped below zero");
	property p_fast_drain;
		@(posedge clk_i) disable iff (rst_i)
			s_quiet_tick and (bus.decay == lbm_pkg::DECAY_RST) && !at_zero |=> count_ff == $past(count_ff) - lbm_pkg::LVL_STEP;
	endproperty
	a_fast_drain: assert property (p_fast_drain) else $error("fastest decay did not drain each period");
	property p_hold;
		@(posedge clk_i) disable iff (rst_i) !(ce_i && bus.tick) |=> $stable(count_ff);
	endproperty
	a_hold: assert property (p_hold) else $error("bucket moved between evaluations");
	property p_run_bound;
		@(posedge clk_i) disable iff (rst_i) ce_i && bus.tick |=> run_ff < $past(run_len);
	endproperty
	a_run_bound: assert property (p_run_bound) else $error("quiet run exceeded selected length");
	property p_raise;
		@(posedge clk_i) disable iff (rst_i) $rose(alarm_ff) |-> count_ff >= $past(bus.set_lvl) && raise_ff;
	endproperty
	a_raise: assert property (p_raise) else $error("alarm raised below set level");
	property p_clear;
		@(posedge clk_i) disable iff (rst_i) $fell(alarm_ff) |-> count_ff <= $past(bus.clr_lvl) && clear_ff;
	endproperty
	a_clear: assert property (p_clear) else $error("alarm cleared above clear level");
endmodule
`default_nettype wire

// [leaky_bucket_activity_monitor_tb.sv]
`timescale 1ns/1ns
`default_nettype none
module leaky_bucket_activity_monitor_tb;
	// ****************************************
	// bench signals and model state
	// ****************************************
	localparam logic [23:0] EVC = 24'h000010;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic ce_i = 1'b1;
	logic fault_i = 1'b0;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0;
	logic [7:0] wb_adr_i = 8'h00;
	logic [3:0] wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h00000000;
	logic [31:0] wb_dat_o;
	logic wb_ack_o;
	logic alarm_o;
	logic irq_o;
	logic [3:0] ph = 4'h0;
	logic f_prev = 1'b0;
	logic nxt_fault = 1'b0;
	logic [7:0] m_cnt, m_set, m_clr;
	logic [1:0] m_decay, m_stat, m_mask;
	logic m_alarm;
	int m_run;
	int n_mismatch = 0;
	int total_checks = 0;
	logic [31:0] rd;
	logic [31:0] keep;
	logic [31:0] rstv [0:6] = '{32'h00000006, 32'h00000004, 32'h00000000, 32'h00000000, 32'h00000000,
		32'h00000000, 32'h00000000};
	logic [7:0] rw_adr [0:4] = '{8'h00, 8'h04, 8'h08, 8'h14, 8'h18};
	logic [31:0] rw_msk [0:4] = '{32'h000000FF, 32'h000000FF, 32'h00000003, 32'h00000003, 32'h00000000};

	leaky_bucket_activity_monitor #(.EVAL_CYC(EVC)) i_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
		.fault_i(fault_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
		.wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .alarm_o(alarm_o),
		.irq_o(irq_o));

	// clock generation
	always #5 clk_i = ~clk_i;

	// phase counter mirroring the evaluation timer; fault changes mid period only, far from ticks
	always @(posedge clk_i) begin
		if (rst_i) begin
			ph <= 4'h0;
			f_prev <= 1'b0;
			fault_i <= 1'b0;
		end else if (ce_i) begin
			ph <= ph + 4'h1;
			if (ph == 4'h8) begin
				f_prev <= fault_i;
				fault_i <= nxt_fault;
			end
		end
	end

	// ****************************************
	// checking and bus tasks
	// ****************************************
	task automatic conclude();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// one classic cycle; the request holds until ack is sampled high
	task automatic wb(input logic we, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_sel_i <= s;
		wb_dat_i <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 50);
		if (n >= 50) chk("wb_ack", 32'h00000000, 32'h00000001);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask

	// ****************************************
	// reference model of the bucket
	// ****************************************
	task automatic minit();
		m_cnt = 8'h00;
		m_set = 8'h06;
		m_clr = 8'h04;
		m_decay = 2'h0;
		m_stat = 2'h0;
		m_mask = 2'h0;
		m_alarm = 1'b0;
		m_run = 0;
	endtask

	task automatic eval_alarm();
		if (!m_alarm && m_cnt >= m_set) begin
			m_alarm = 1'b1;
			m_stat[0] = 1'b1;
		end else if (m_alarm && m_cnt <= m_clr) begin
			m_alarm = 1'b0;
			m_stat[1] = 1'b1;
		end
	endtask

	task automatic upd(input logic f);
		if (f) begin
			if (m_cnt != 8'hFF) m_cnt = m_cnt + 8'h01;
			m_run = 0;
		end else begin
			m_run = m_run + 1;
			if (m_run >= (1 << m_decay)) begin
				if (m_cnt != 8'h00) m_cnt = m_cnt - 8'h01;
				m_run = 0;
			end
		end
		eval_alarm();
	endtask

	// one evaluation period: mode 0 quiet, 1 faulty, 2 random with a random register access
	task automatic per(input int mode, input bit upd_en);
		int op;
		int v;
		logic [31:0] d;
		do @(posedge clk_i); while (ph != 4'h2);
		if (upd_en) upd(f_prev | fault_i);
		nxt_fault <= (mode == 2) ? ($urandom % 3 == 0) : mode[0];
		wb(1'b0, lbm_pkg::ADR_BUCKET, 4'hF, 32'h00000000);
		chk("bucket", rd, {23'h000000, m_alarm, m_cnt});
		chk("alarm_o", {31'h00000000, alarm_o}, {31'h00000000, m_alarm});
		wb(1'b0, lbm_pkg::ADR_IRQ_STAT, 4'hF, 32'h00000000);
		chk("irq_stat", rd, {30'h00000000, m_stat});
		chk("irq_o", {31'h00000000, irq_o}, {31'h00000000, |(m_stat & m_mask)});
		if (mode == 2) begin
			op = $urandom % 5;
			d = $urandom;
			case (op)
				0: begin
					wb(1'b1, lbm_pkg::ADR_IRQ_MASK, 4'hF, d);
					m_mask = d[1:0];
				end
				1: begin
					wb(1'b1, lbm_pkg::ADR_IRQ_STAT, 4'hF, d);
					m_stat = m_stat & ~d[1:0];
				end
				2: begin
					v = m_clr + 2 + ($urandom % 16);
					if (v <= 255) begin
						wb(1'b1, lbm_pkg::ADR_SET_LVL, 4'hF, 32'(v));
						m_set = 8'(v);
						eval_alarm();
					end
				end
				3: begin
					v = $urandom % (m_set - 1);
					wb(1'b1, lbm_pkg::ADR_CLR_LVL, 4'hF, 32'(v));
					m_clr = 8'(v);
					eval_alarm();
				end
				default: begin
					if (m_run == 0) begin
						wb(1'b1, lbm_pkg::ADR_DECAY, 4'hF, d);
						m_decay = d[1:0];
					end
				end
			endcase
		end
	endtask

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		int i;
		logic [31:0] d;
		void'($urandom(16));
		minit();
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		// reset values, including an unmapped word
		for (i = 0; i < 7; i++) begin
			wb(1'b0, 8'(i * 4), 4'hF, 32'h00000000);
			chk("reset_value", rd, rstv[i]);
		end
		// read back of random writes; unmapped word stays zero
		for (i = 0; i < 5; i++) begin
			d = $urandom;
			wb(1'b1, rw_adr[i], 4'hF, d);
			if (i == 1) keep = d;
			wb(1'b0, rw_adr[i], 4'hF, 32'h00000000);
			chk("readback", rd, d & rw_msk[i]);
		end
		// write without the low byte lane is ignored
		wb(1'b1, lbm_pkg::ADR_CLR_LVL, 4'hE, ~d);
		wb(1'b0, lbm_pkg::ADR_CLR_LVL, 4'hF, 32'h00000000);
		chk("sel_ignore", rd, keep & rw_msk[1]);
		// second reset in mid run, then model and design start together
		rst_i <= 1'b1;
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		minit();
		per(2, 1'b0);
		wb(1'b1, lbm_pkg::ADR_IRQ_MASK, 4'hF, 32'h00000003);
		m_mask = 2'h3;
		repeat (60) per(2, 1'b1);
		// fill to saturation with a high set level, then drain to zero
		per(1, 1'b1);
		wb(1'b1, lbm_pkg::ADR_SET_LVL, 4'hF, 32'h000000FE);
		m_set = 8'hFE;
		eval_alarm();
		per(1, 1'b1);
		wb(1'b1, lbm_pkg::ADR_CLR_LVL, 4'hF, 32'h00000002);
		m_clr = 8'h02;
		eval_alarm();
		repeat (262) per(1, 1'b1);
		wb(1'b1, lbm_pkg::ADR_DECAY, 4'hF, 32'h00000000);
		m_decay = 2'h0;
		// clock enable low freezes the timer and bucket
		ce_i <= 1'b0;
		repeat (30) @(posedge clk_i);
		ce_i <= 1'b1;
		repeat (262) per(0, 1'b1);
		repeat (80) per(2, 1'b1);
		conclude();
	end

	// watchdog cuts a hang short
	initial begin
		repeat (30000) @(posedge clk_i);
		n_mismatch++;
		conclude();
	end
endmodule
`default_nettype wire
